// ---- logic/rsfc_config.v ----
// Startup-timeout and frequency-compensation configuration registers with chip-ready sequencing
`timescale 1ns/1ps
`include "rsfc_map.vh"

// Operation
// - After crystal stable, chip-ready stays not-ready until ripple counter expires 1/16/64/256 times.
// - Timeout field resets to code 1; delay scales with crystal clock.
// - Bit 1 enables pin radio control; resets to 0.
// - Bit 0 keeps crystal running in sleep; resets to 0.
// - Gate bit set freezes compensation and clock recovery loops until carrier sense.
// - Pre-sync loop gain follows bits 4:3: K, 2K, 3K, 4K; reset code 2.
// - Post-sync gain bit 2: 0 keeps pre-sync gain, 1 selects K/2; resets 1.
// - Bits 1:0 set saturation: off, BW/8, BW/4, BW/2; reset code 2.
module rsfc_config (
    // Clock and reset
    input  wire       CORE_CLK_IN,
    input  wire       SYS_RST_IN,
    // Register port
    input  wire       REG_WR_IN,
    input  wire [7:0] REG_ADDR_IN,
    input  wire [7:0] REG_WDATA_IN,
    output reg  [7:0] REG_RDATA_OUT,
    // Crystal startup
    input  wire       XTAL_STABLE_IN,
    output reg        CHIP_READY_N_OUT,
    // Demodulator status
    input  wire       CARRIER_SENSE_IN,
    input  wire       SYNC_FOUND_IN,
    input  wire       RX_ACTIVE_IN,
    // Configuration to radio and demodulator
    output reg        PIN_CTRL_EN_OUT,
    output reg        CRYSTAL_KEEP_ON_OUT,
    output reg        LOOPS_FROZEN_OUT,
    output reg  [3:0] COMP_GAIN_OUT,
    output reg  [1:0] COMP_SAT_SHIFT_OUT
);

    // Host-visible configuration registers
    // Only the documented bits are stored; the rest are tied off by masks
    reg  [7:0] radio_ctrl;
    reg  [7:0] comp_cfg;

    // Three-flop pin synchronisers and their qualified levels
    // A level is taken only when the last two stages agree, filtering glitches
    reg  [2:0] stable_sync;
    reg  [2:0] cs_sync;
    reg        stable_q;
    reg        cs_q;

    // Carrier seen since the receiver became active
    reg        carrier_seen;

    // Startup timer: six-bit ripple counter and its wrap counter
    // Wrap counter is nine bits so that 256 wraps fit without overflow
    reg  [5:0] ripple;
    reg  [8:0] expire_cnt;
    reg  [8:0] expire_goal;

    // Decoded loop settings before registering
    reg  [3:0] next_gain;
    reg  [1:0] next_sat;

    // Counter events
    // Wrap is seen on the last count, so one expiry takes a full 64 cycles
    wire       ripple_wrap = (ripple == `RSFC_RIPPLE_MAX);
    wire       target_hit  = (expire_cnt == expire_goal);

    // Register writes; masks drop reserved bits
    // Writes to any other address fall through and change nothing
    // Reserved bits never reach a flop, so read-back of them is zero for free
    always @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            radio_ctrl <= `RSFC_RADIO_CTRL_RST;
            comp_cfg   <= `RSFC_COMP_CFG_RST;
        end else if (REG_WR_IN) begin
            if (REG_ADDR_IN == `RSFC_ADDR_RADIO_CTRL) begin
                radio_ctrl <= REG_WDATA_IN & `RSFC_RADIO_CTRL_MASK;
            end else if (REG_ADDR_IN == `RSFC_ADDR_COMP_CFG) begin
                comp_cfg <= REG_WDATA_IN & `RSFC_COMP_CFG_MASK;
            end
        end
    end

    // Read data registered; unmapped addresses read zero
    // Registering costs one cycle of latency but keeps the read path glitch free
    // Data follows the address every cycle; there is no read strobe
    always @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            REG_RDATA_OUT <= 8'h00;
        end else if (REG_ADDR_IN == `RSFC_ADDR_RADIO_CTRL) begin
            REG_RDATA_OUT <= radio_ctrl;
        end else if (REG_ADDR_IN == `RSFC_ADDR_COMP_CFG) begin
            REG_RDATA_OUT <= comp_cfg;
        end else begin
            REG_RDATA_OUT <= 8'h00;
        end
    end

    // Pin inputs pass three flops; change taken when last two agree
    // Both pins are asynchronous to the core clock
    // Qualified level lags the pin by about four cycles
    // Reset level is low, matching the idle level of both pins
    always @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            stable_sync <= 3'h0;
            cs_sync     <= 3'h0;
            stable_q    <= 1'h0;
            cs_q        <= 1'h0;
        end else begin
            stable_sync <= {stable_sync[1:0], XTAL_STABLE_IN};
            cs_sync     <= {cs_sync[1:0], CARRIER_SENSE_IN};
            if (stable_sync[2] == stable_sync[1]) begin
                stable_q <= stable_sync[2];
            end
            if (cs_sync[2] == cs_sync[1]) begin
                cs_q <= cs_sync[2];
            end
        end
    end

    // Expire count chosen by the timeout field
    // A change while counting takes effect at the next comparison
    // Shortening below the count already reached leaves ready waiting for a wrap-around
    always @* begin
        case (radio_ctrl[`RSFC_TMO_HI:`RSFC_TMO_LO])
            2'h0:    expire_goal = `RSFC_EXPIRE_C0;
            2'h1:    expire_goal = `RSFC_EXPIRE_C1;
            2'h2:    expire_goal = `RSFC_EXPIRE_C2;
            default: expire_goal = `RSFC_EXPIRE_C3;
        endcase
    end

    // Ripple counter runs on the crystal-derived clock, so delay scales with it
    // Loss of crystal stable restarts the whole sequence from zero
    // Once ready the counter stops, saving toggles while the radio runs
    // Ready falls one cycle after the last expiry is counted
    always @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN || !stable_q) begin
            ripple           <= 6'h00;
            expire_cnt       <= 9'h000;
            CHIP_READY_N_OUT <= 1'h1;
        end else if (CHIP_READY_N_OUT) begin
            ripple <= ripple + 6'h01;
            if (ripple_wrap) begin
                expire_cnt <= expire_cnt + 9'h001;
            end
            // Ready only once the chosen number of wraps has completed
            if (target_hit) begin
                CHIP_READY_N_OUT <= 1'h0;
            end
        end
    end

    // Carrier latch per reception; cleared when receiver goes idle
    // Keeps the loops running if carrier sense drops inside a packet
    // Limitation: receiver-idle clear takes priority, so with the gate set each reception starts frozen unless carrier sense is already high
    always @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN || !RX_ACTIVE_IN) begin
            carrier_seen <= 1'h0;
        end else if (cs_q) begin
            carrier_seen <= 1'h1;
        end
    end

    // Gain and saturation decode
    // Gain is carried in units of K/2 so that K/2 needs no fraction
    // Saturation is a right shift of the channel bandwidth; zero means off
    // Sync input is on the core clock already, so it needs no synchroniser
    always @* begin
        case (comp_cfg[`RSFC_PRE_HI:`RSFC_PRE_LO])
            2'h0:    next_gain = `RSFC_GAIN_K;
            2'h1:    next_gain = `RSFC_GAIN_2K;
            2'h2:    next_gain = `RSFC_GAIN_3K;
            default: next_gain = `RSFC_GAIN_4K;
        endcase
        if (SYNC_FOUND_IN && comp_cfg[`RSFC_POST_BIT]) begin
            next_gain = `RSFC_GAIN_HALF_K;
        end
        case (comp_cfg[`RSFC_LIM_HI:`RSFC_LIM_LO])
            2'h0:    next_sat = `RSFC_SAT_OFF;
            2'h1:    next_sat = `RSFC_SAT_DIV8;
            2'h2:    next_sat = `RSFC_SAT_DIV4;
            default: next_sat = `RSFC_SAT_DIV2;
        endcase
    end

    // Registered configuration outputs
    // Outputs follow a register write one cycle later
    // Reset values mirror the register reset values
    // Loops start frozen because the gate bit resets to one
    always @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            PIN_CTRL_EN_OUT     <= 1'h0;
            CRYSTAL_KEEP_ON_OUT <= 1'h0;
            LOOPS_FROZEN_OUT    <= 1'h1;
            COMP_GAIN_OUT       <= `RSFC_GAIN_3K;
            COMP_SAT_SHIFT_OUT  <= `RSFC_SAT_DIV4;
        end else begin
            PIN_CTRL_EN_OUT     <= radio_ctrl[`RSFC_PIN_CTRL_BIT];
            CRYSTAL_KEEP_ON_OUT <= radio_ctrl[`RSFC_XTAL_KEEP_BIT];
            LOOPS_FROZEN_OUT    <= comp_cfg[`RSFC_GATE_BIT] & ~(carrier_seen | cs_q);
            COMP_GAIN_OUT       <= next_gain;
            COMP_SAT_SHIFT_OUT  <= next_sat;
        end
    end

endmodule

// ---- logic/rsfc_map.vh ----
// Register offsets, field positions, reset values and codes for the startup/compensation config block
`ifndef RSFC_MAP_VH
`define RSFC_MAP_VH

// Register addresses
`define RSFC_ADDR_RADIO_CTRL   8'h17
`define RSFC_ADDR_COMP_CFG     8'h18

// Radio-control register fields
`define RSFC_TMO_HI            3
`define RSFC_TMO_LO            2
`define RSFC_PIN_CTRL_BIT      1
`define RSFC_XTAL_KEEP_BIT     0
`define RSFC_RADIO_CTRL_RST    8'h04
`define RSFC_RADIO_CTRL_MASK   8'h0F

// Compensation register fields
`define RSFC_GATE_BIT          5
`define RSFC_PRE_HI            4
`define RSFC_PRE_LO            3
`define RSFC_POST_BIT          2
`define RSFC_LIM_HI            1
`define RSFC_LIM_LO            0
`define RSFC_COMP_CFG_RST      8'h36
`define RSFC_COMP_CFG_MASK     8'h3F

// Startup timing
`define RSFC_RIPPLE_MAX        6'h3F
`define RSFC_EXPIRE_C0         9'h001
`define RSFC_EXPIRE_C1         9'h010
`define RSFC_EXPIRE_C2         9'h040
`define RSFC_EXPIRE_C3         9'h100

// Gain codes: multiples of K/2 (so K/2 = 1, K = 2 ... 4K = 8)
`define RSFC_GAIN_HALF_K       4'h1
`define RSFC_GAIN_K            4'h2
`define RSFC_GAIN_2K           4'h4
`define RSFC_GAIN_3K           4'h6
`define RSFC_GAIN_4K           4'h8

// Saturation shift of channel bandwidth (0 means compensation off)
`define RSFC_SAT_OFF           2'h0
`define RSFC_SAT_DIV8          2'h3
`define RSFC_SAT_DIV4          2'h2
`define RSFC_SAT_DIV2          2'h1

`endif

// ---- test/rsfc_config_properties.sv ----
// Port-level properties of the rsfc config block
`timescale 1ns/1ps
module rsfc_chk (
    input wire       CORE_CLK_IN, SYS_RST_IN, REG_WR_IN, XTAL_STABLE_IN, CHIP_READY_N_OUT,
    input wire       CARRIER_SENSE_IN, SYNC_FOUND_IN, PIN_CTRL_EN_OUT, CRYSTAL_KEEP_ON_OUT, LOOPS_FROZEN_OUT,
    input wire [7:0] REG_ADDR_IN, REG_RDATA_OUT,
    input wire [3:0] COMP_GAIN_OUT,
    input wire [1:0] COMP_SAT_SHIFT_OUT
);
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);
    // Quiet windows: no write for three edges, so read-back equals the register
    wire [7:0] rd  = REG_RDATA_OUT;
    wire       q17 = REG_ADDR_IN == 8'h17 && !REG_WR_IN;
    wire       q18 = REG_ADDR_IN == 8'h18 && !REG_WR_IN;
    wire [3:0] pre = {1'b0, rd[4:3], 1'b0} + 4'h2;
    AST_RSVD: assert property (q18 |=> rd[7:6] == 2'h0) else $error("reserved set");
    AST_IDLE: assert property (!XTAL_STABLE_IN [*6] |=> CHIP_READY_N_OUT) else $error("early ready");
    AST_WAIT: assert property ($fell(CHIP_READY_N_OUT) |-> $past(XTAL_STABLE_IN, 64)) else $error("short");
    AST_THAW: assert property (CARRIER_SENSE_IN [*6] |-> !LOOPS_FROZEN_OUT) else $error("frozen");
    AST_PRE: assert property ((q18 && !SYNC_FOUND_IN) [*3] |-> COMP_GAIN_OUT == pre) else $error("gain");
    AST_POST: assert property ((q18 && SYNC_FOUND_IN) [*3] |-> COMP_GAIN_OUT == (rd[2] ? 4'h1 : pre))
        else $error("post gain");
    AST_SAT: assert property (q18 [*3] |-> COMP_SAT_SHIFT_OUT == 2'h0 - rd[1:0]) else $error("limit");
    AST_RADIO: assert property (q17 [*3] |-> {PIN_CTRL_EN_OUT, CRYSTAL_KEEP_ON_OUT} == rd[1:0])
        else $error("radio bits");
    cover property ($fell(CHIP_READY_N_OUT));
    cover property (SYNC_FOUND_IN && COMP_GAIN_OUT == 4'h1);
    cover property ($fell(LOOPS_FROZEN_OUT));
endmodule
bind rsfc_config rsfc_chk u_chk (.*);

// ---- test/rsfc_host.sv ----
// Host model: register cycles and crystal-stable level
`timescale 1ns/1ps
module rsfc_host (
    input  wire       clk,
    input  wire [7:0] rdata,
    output reg        wr    = 1'b0,
    output reg  [7:0] addr  = 8'h00,
    output reg  [7:0] wdata = 8'h00,
    output reg        xtal  = 1'b0
);
    // One-cycle strobe; data inverted after, so a stale value never looks valid
    task wr_reg(input [7:0] a, input [7:0] v);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, v};
        @(posedge clk);
        {wr, wdata} <= {1'b0, ~v};
    endtask
    // Read data lags the address by one edge
    task rd_reg(input [7:0] a, output [7:0] v);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1 v = rdata;
    endtask
endmodule

// ---- test/tb_radio_startup_and_freq_comp_config.sv ----
// Self-checking bench for the rsfc config block
`timescale 1ns/1ps
module tb_radio_startup_and_freq_comp_config;
    reg        clk = 1'b0, rst = 1'b1, cs = 1'b0, sync = 1'b0, rx = 1'b0;
    wire       wr, xtal, rdy_n, pin, keep, frz;
    wire [7:0] addr, wdata, rdata;
    wire [3:0] gain;
    wire [1:0] sat;
    reg  [7:0] d;
    integer    bad_count = 0, samples_checked = 0, i, n, lim;
    rsfc_config dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .REG_WR_IN(wr), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .XTAL_STABLE_IN(xtal), .CHIP_READY_N_OUT(rdy_n),
        .CARRIER_SENSE_IN(cs), .SYNC_FOUND_IN(sync), .RX_ACTIVE_IN(rx), .PIN_CTRL_EN_OUT(pin),
        .CRYSTAL_KEEP_ON_OUT(keep), .LOOPS_FROZEN_OUT(frz), .COMP_GAIN_OUT(gain), .COMP_SAT_SHIFT_OUT(sat));
    rsfc_host h (.clk(clk), .rdata(rdata), .wr(wr), .addr(addr), .wdata(wdata), .xtal(xtal));
    // 100 ns clock
    initial forever #50 clk = ~clk;
    // Compare and count; report a mismatch at once
    task chk(input [7:0] a, input [7:0] b);
        samples_checked++;
        if (a !== b) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Reset values of both registers and all outputs
    task t_reset;
        h.rd_reg(8'h17, d);
        chk(d, 8'h04);
        h.rd_reg(8'h18, d);
        chk(d, 8'h36);
        chk({frz, rdy_n, pin, keep, gain}, 8'hC6);
        chk(sat, 8'h02);
    endtask
    // Reserved bits, a stray address, then every gain and limit code
    task t_fields;
        h.wr_reg(8'h18, 8'hFF);
        h.wr_reg(8'h17, 8'h03);
        h.wr_reg(8'h20, 8'h00);
        h.rd_reg(8'h18, d);
        chk(d, 8'h3F);
        chk({pin, keep}, 8'h03);
        for (n = 0; n < 4; n++) begin
            h.wr_reg(8'h18, n * 9);
            repeat (2) @(posedge clk);
            chk(gain, n * 2 + 2);
            chk(sat, (4 - n) % 4);
        end
    endtask
    // After sync: K/2, or the pre-sync gain kept
    task t_sync;
        h.wr_reg(8'h18, 8'h14);
        sync <= 1'b1;
        repeat (3) @(posedge clk);
        chk(gain, 8'h01);
        h.wr_reg(8'h18, 8'h10);
        repeat (2) @(posedge clk);
        chk(gain, 8'h06);
        sync <= 1'b0;
    endtask
    // Frozen until carrier sense; never frozen with the gate off
    task t_gate;
        h.wr_reg(8'h18, 8'h34);
        rx <= 1'b1;
        repeat (8) @(posedge clk);
        chk({frz, sat}, 8'h04);
        cs <= 1'b1;
        repeat (8) @(posedge clk);
        chk(frz, 8'h00);
        {cs, rx} <= 2'b00;
        repeat (8) @(posedge clk);
        chk(frz, 8'h01);
        h.wr_reg(8'h18, 8'h14);
        repeat (6) @(posedge clk);
        chk(frz, 8'h00);
    endtask
    // Chip-ready delay per timeout code; ready drops with the crystal
    task t_start;
        for (n = 0; n < 4; n++) begin
            h.wr_reg(8'h17, n * 4);
            h.xtal <= 1'b1;
            lim = n ? 64 << (2 * n + 2) : 64;
            for (i = 0; i < lim + 20 && rdy_n === 1'b1; i++) @(posedge clk);
            chk(i >= lim && i <= lim + 10, 8'h01);
            if (i == lim + 20) tally_and_finish;
            h.xtal <= 1'b0;
            repeat (8) @(posedge clk);
            chk(rdy_n, 8'h01);
        end
    endtask
    // Ten reset cycles, then the scenarios
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_fields;
        t_sync;
        t_gate;
        t_start;
        tally_and_finish;
    end
endmodule
